//--- test/bdaf_core_model.sv
// core-side sink that collects transmitted alert headers
module bdaf_core_model (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// transmit byte stream from the framer
	input  wire logic        tx_valid,
	input  wire logic [7:0]  tx_data,
	input  wire logic        tx_first,
	input  wire logic        tx_last,
	output logic             tx_ready,
	// bench control and collected header
	input  wire logic        slow,
	output logic [63:0]      hdr,
	output logic [3:0]       hdr_len,
	output logic             hdr_done
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [3:0] cnt;

	// ****************************************************
	// stalls every other cycle when slow
	// ****************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			tx_ready <= 1'h0;
		else
			tx_ready <= slow ? ~tx_ready : 1'h1;
	end

	// ****************************************************
	// byte collection; reserved content is never judged here
	// ****************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hdr      <= 64'h0;
			cnt      <= 4'h0;
			hdr_len  <= 4'h0;
			hdr_done <= 1'h0;
		end else begin
			hdr_done <= 1'h0;
			if (tx_valid && tx_ready) begin
				hdr <= {hdr[55:0], tx_data};
				cnt <= tx_first ? 4'h1 : cnt + 4'h1;
				if (tx_last) begin
					hdr_len  <= tx_first ? 4'h1 : cnt + 4'h1;
					hdr_done <= 1'h1;
				end
			end
		end
	end
endmodule

//--- test/buffer_depth_alert_header_framer_tb.sv
// self-checking bench for the alert header framer
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
	$display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module buffer_depth_alert_header_framer_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk, rst_n, alert_req, multi_chan, arm, armed, slow;
	logic [7:0]  alert_chan, tx_data, rx_data, rx_alert_chan;
	logic        tx_valid, tx_first, tx_last, tx_ready;
	logic        rx_valid, rx_first, rx_alert, hdr_done;
	logic [63:0] hdr;
	logic [3:0]  hdr_len;
	logic [7:0]  rx_chan_exp;
	int          miscompares = 0;
	int          tests_run = 0;

	bdaf_framer uut (.clk(clk), .rst_n(rst_n), .alert_req(alert_req),
		.alert_chan(alert_chan), .multi_chan(multi_chan), .arm(arm),
		.armed(armed), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_first(tx_first), .tx_last(tx_last), .tx_ready(tx_ready),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_first(rx_first),
		.rx_alert(rx_alert), .rx_alert_chan(rx_alert_chan));

	bdaf_core_model core (.clk(clk), .rst_n(rst_n), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_first(tx_first), .tx_last(tx_last),
		.tx_ready(tx_ready), .slow(slow), .hdr(hdr), .hdr_len(hdr_len),
		.hdr_done(hdr_done));

	// ****************************************************
	// helpers
	// ****************************************************
	task automatic tick;
		@(posedge clk);
		#5;
	endtask

	task automatic end_sim;
		$display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic send_alert(input logic [7:0] ch, input logic mc,
		input logic slw);
		int n;
		slow = slw;
		arm = 1'h1;
		tick;
		arm = 1'h0;
		alert_req = 1'h1;
		alert_chan = ch;
		multi_chan = mc;
		n = 0;
		while (tx_valid !== 1'h1 && n < 20) begin
			tick;
			n++;
		end
		`CHK(armed, 1'h0)
		`CHK(tx_first, 1'h1)
		// channel is sampled only at accept, so later changes must not leak
		alert_chan = ~ch;
		n = 0;
		while (hdr_done !== 1'h1 && n < 40) begin
			tick;
			n++;
		end
		`CHK(hdr_done, 1'h1)
		`CHK(hdr_len, 4'h8)
		`CHK(hdr[63], 1'h0)
		`CHK(hdr[62], 1'h0)
		`CHK(hdr[61:60], 2'h1)
		`CHK(hdr[59], 1'h0)
		`CHK(hdr[58:56], 3'h0)
		`CHK(hdr[55:52], 4'h0)
		`CHK(hdr[51:48], 4'h1)
		`CHK(hdr[47:40], 8'h00)
		`CHK(hdr[39:32], 8'h00)
		`CHK(hdr[31:24], mc ? ch : 8'h00)
		`CHK(hdr[23:0], 24'h000000)
		// request still held but not re-armed: nothing may go out
		repeat (4) begin
			tick;
			`CHK(tx_valid, 1'h0)
		end
		alert_req = 1'h0;
	endtask

	// only extension marker 01 with function 0001 makes an alert
	function automatic logic rx_is_alert(input logic [3:0] fn,
		input logic [1:0] ext);
		return fn == 4'h1 && ext == 2'h1;
	endfunction

	task automatic send_rx(input logic [3:0] fn, input logic [7:0] ch,
		input logic [1:0] ext);
		logic [63:0] h;
		h = {$urandom, $urandom};
		h[61:60] = ext;
		h[51:48] = fn;
		h[31:24] = ch;
		for (int i = 0; i < 8; i++) begin
			rx_valid = 1'h1;
			rx_first = (i == 0);
			rx_data = h[63 - 8 * i -: 8];
			tick;
		end
		rx_valid = 1'h0;
		rx_first = 1'h0;
		// the channel output keeps its value unless an alert is seen
		if (rx_is_alert(fn, ext))
			rx_chan_exp = ch;
		`CHK(rx_alert, 1'h0)
		tick;
		`CHK(rx_alert, rx_is_alert(fn, ext))
		`CHK(rx_alert_chan, rx_chan_exp)
		tick;
		`CHK(rx_alert, 1'h0)
	endtask

	// ****************************************************
	// clock, watchdog and main sequence
	// ****************************************************
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end

	initial begin
		#400000;
		miscompares++;
		end_sim;
	end

	initial begin
		rst_n = 1'h0;
		alert_req = 1'h0;
		alert_chan = 8'h00;
		multi_chan = 1'h0;
		arm = 1'h0;
		slow = 1'h0;
		rx_valid = 1'h0;
		rx_data = 8'h00;
		rx_first = 1'h0;
		rx_chan_exp = 8'h00;
		void'($urandom(57989));
		repeat (8) @(posedge clk);
		#5;
		rst_n = 1'h1;
		tick;
		send_alert(8'hFF, 1'h1, 1'h1);
		send_alert(8'h2A, 1'h0, 1'h0);
		repeat (30)
			send_alert(8'($urandom), 1'($urandom), 1'($urandom));
		send_rx(4'h1, 8'h00, 2'h1);
		send_rx(4'h0, 8'h55, 2'h1);
		send_rx(4'h1, 8'h77, 2'h3);
		send_rx(4'h1, 8'h66, 2'h0);
		send_rx(4'h1, 8'h3C, 2'h1);
		repeat (30)
			send_rx(4'($urandom_range(3)), 8'($urandom),
				($urandom_range(3) == 0) ? 2'($urandom) : 2'h1);
		end_sim;
	end
endmodule

//--- verilog/bdaf_framer.sv
// buffer depth alert header framer: transmit packer and armed state
//
// Overview of operation
// - connectivity-verification flag bit is always sent as zero.
// - sequencing flag bit is sent as zero; no sequence number carried.
// - two-bit extended header indicator is sent as binary 01.
// - reserved bit after the extended header indicator is sent as zero.
// - three-bit queue_stream_index field is sent as all zeros.
// - four-bit reserved field before the function code is zero.
// - function code is 0001, marking a buffer depth alert.
// - reserved byte after the function code is sent as zero.
// - transaction identifier byte is unused and sent as zero.
// - channel byte carries the channel id or program_group_label from setup.
// - with several channels, channel byte names the channel that alerted.
// - with a single channel, the channel byte is sent as zero.
// - final three reserved bytes are sent as zeros.
// - exactly one alert per armed period when the average crosses.
module bdaf_framer (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// alert request from the depth average comparator
	input  wire logic       alert_req,
	input  wire logic [7:0] alert_chan,
	input  wire logic       multi_chan,
	// monitoring control from the core
	input  wire logic       arm,
	output logic            armed,
	// transmit byte stream
	output logic            tx_valid,
	output logic [7:0]      tx_data,
	output logic            tx_first,
	output logic            tx_last,
	input  wire logic       tx_ready,
	// receive byte stream
	input  wire logic       rx_valid,
	input  wire logic [7:0] rx_data,
	input  wire logic       rx_first,
	output logic            rx_alert,
	output logic [7:0]      rx_alert_chan
);

	// ****************************************************
	// declarations
	// ****************************************************
	typedef enum logic {
		st_idle,
		st_send
	} bdaf_state_t;

	bdaf_state_t                state;
	logic [bdaf_pkg::HDR_W-1:0] hdr;
	logic [2:0]                 cnt;
	logic                       accept;
	logic                       step;
	logic [7:0]                 chan_sel;

	bdaf_rx_if rif ();

	// ****************************************************
	// request acceptance and arming
	// ****************************************************
	// a request while unarmed or mid-frame is dropped: the comparator
	// re-raises it while the average stays high, so nothing is lost
	assign accept   = alert_req && armed && state == st_idle;
	assign step     = tx_valid && tx_ready;
	assign chan_sel = multi_chan ? alert_chan
		: bdaf_pkg::CHAN_NONE;

	// re-arming in the same cycle as an accepted alert wins
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			armed <= 1'h0;
		else if (arm)
			armed <= 1'h1;
		else if (accept)
			armed <= 1'h0;
	end

	// ****************************************************
	// frame sequencing
	// ****************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= st_idle;
			cnt   <= 3'h0;
		end else begin
			unique case (state)
				st_idle: begin
					if (accept) begin
						state <= st_send;
						cnt   <= 3'h0;
					end
				end
				st_send: begin
					if (step) begin
						if (cnt == bdaf_pkg::LAST_BYTE)
							state <= st_idle;
						cnt <= cnt + 3'h1;
					end
				end
			endcase
		end
	end

	// ****************************************************
	// header packing and byte output
	// ****************************************************
	// whole header is built at once so the channel cannot change
	// half way through the frame
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hdr     <= '0;
			tx_data <= 8'h00;
		end else if (accept) begin
			hdr     <= bdaf_pkg::build_header(chan_sel);
			tx_data <= bdaf_pkg::build_header(chan_sel)
				[bdaf_pkg::HDR_W-1 -: bdaf_pkg::BYTE_W];
		end else if (step) begin
			hdr     <= {hdr[bdaf_pkg::HDR_W-bdaf_pkg::BYTE_W-1:0],
				8'h00};
			tx_data <= hdr[bdaf_pkg::HDR_W-bdaf_pkg::BYTE_W-1
				-: bdaf_pkg::BYTE_W];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_valid <= 1'h0;
			tx_first <= 1'h0;
			tx_last  <= 1'h0;
		end else if (accept) begin
			tx_valid <= 1'h1;
			tx_first <= 1'h1;
			tx_last  <= 1'h0;
		end else if (step) begin
			tx_valid <= cnt != bdaf_pkg::LAST_BYTE;
			tx_first <= 1'h0;
			tx_last  <= cnt == bdaf_pkg::LAST_BYTE - 3'h1;
		end
	end

	// ****************************************************
	// receive side
	// ****************************************************
	bdaf_rx_parser u_rx (
		.clk      (clk),
		.rst_n    (rst_n),
		.rx_valid (rx_valid),
		.rx_data  (rx_data),
		.rx_first (rx_first),
		.rif      (rif.parser)
	);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_alert      <= 1'h0;
			rx_alert_chan <= 8'h00;
		end else begin
			rx_alert <= rif.alert_seen;
			if (rif.alert_seen)
				rx_alert_chan <= rif.alert_chan;
		end
	end

	// ****************************************************
	// assertions
	// ****************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// expected channel, captured independently of the packer
	logic [7:0] exp_chan;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			exp_chan <= 8'h00;
		else if (alert_req && armed && !tx_valid)
			exp_chan <= multi_chan ? alert_chan : 8'h00;
	end

	a_cv_flag_zero: assert property (
		tx_valid && tx_first |-> tx_data[bdaf_pkg::B0_CV_BIT]
			== bdaf_pkg::CV_VAL)
		else $error("cv flag not zero");

	a_seq_flag_zero: assert property (
		tx_valid && tx_first |-> tx_data[bdaf_pkg::B0_SEQ_BIT]
			== bdaf_pkg::SEQ_VAL)
		else $error("sequence flag not zero");

	a_ext_hdr_code: assert property (
		tx_valid && tx_first |-> tx_data[bdaf_pkg::B0_EXT_LO +: 2]
			== bdaf_pkg::EXT_VAL)
		else $error("extended header indicator not 01");

	a_x_bit_zero: assert property (
		tx_valid && tx_first |-> tx_data[bdaf_pkg::B0_X_BIT]
			== bdaf_pkg::X_VAL)
		else $error("reserved bit not zero");

	a_stream_idx_zero: assert property (
		tx_valid && tx_first |-> tx_data[bdaf_pkg::B0_FLOW_LO +: 3]
			== 3'h0)
		else $error("stream index not zero");

	a_rsv1_zero: assert property (
		tx_valid && tx_first && tx_ready ##1 tx_valid
			|-> tx_data[bdaf_pkg::B1_RSV_LO +: 4] == 4'h0)
		else $error("reserved nibble not zero");

	a_func_code: assert property (
		tx_valid && tx_first && tx_ready ##1 tx_valid
			|-> tx_data[bdaf_pkg::B1_FUNC_LO +: 4]
				== bdaf_pkg::FUNC_ALERT)
		else $error("function code not 0001");

	a_rsv2_zero: assert property (
		tx_valid && cnt == bdaf_pkg::RSV2_BYTE |-> tx_data == 8'h00)
		else $error("reserved byte not zero");

	a_xact_zero: assert property (
		tx_valid && cnt == bdaf_pkg::XACT_BYTE |-> tx_data == 8'h00)
		else $error("transaction byte not zero");

	a_chan_byte: assert property (
		tx_valid && cnt == bdaf_pkg::CHAN_BYTE |-> tx_data == exp_chan)
		else $error("channel byte wrong");

	a_rsv3_zero: assert property (
		tx_valid && cnt > bdaf_pkg::CHAN_BYTE |-> tx_data == 8'h00)
		else $error("trailing reserved bytes not zero");

	a_one_per_arm: assert property (
		accept && !arm |=> !armed && !accept)
		else $error("armed survived an alert");

	a_rearm_needed: assert property (
		$rose(tx_first) |-> $past(armed) && $past(alert_req))
		else $error("frame started without armed request");

	a_last_flag: assert property (
		tx_valid && tx_ready && tx_last |=> !tx_valid
			&& state == st_idle)
		else $error("frame did not end after last byte");

	a_frame_bytes: assert property (
		tx_valid && tx_first && tx_ready ##1 tx_ready [*7]
			|-> tx_last && tx_valid)
		else $error("header not eight bytes long");

	// handshakes seen in the current frame, kept apart from the
	// sequencer count so that a slip in one shows up in the other
	logic [3:0] seen_bytes;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			seen_bytes <= 4'h0;
		else if (accept)
			seen_bytes <= 4'h0;
		else if (step)
			seen_bytes <= seen_bytes + 4'h1;
	end

	a_eight_bytes: assert property (
		step && tx_last |-> seen_bytes == 4'(bdaf_pkg::LAST_BYTE))
		else $error("frame length not eight bytes");

	// a stalled sink must see the same byte until it takes it
	a_byte_held: assert property (
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)
			&& $stable(tx_first) && $stable(tx_last))
		else $error("byte changed while stalled");

	a_mid_frame: assert property (
		step && !tx_last |=> tx_valid)
		else $error("frame broke off before last byte");

	a_last_only_end: assert property (
		tx_last |-> tx_valid && !tx_first)
		else $error("last flag outside final byte");

	a_idle_quiet: assert property (
		!tx_valid |-> !tx_first && !tx_last)
		else $error("frame flags set while idle");

	a_accept_start: assert property (
		accept |=> tx_valid && tx_first && !tx_last)
		else $error("accepted alert did not start a frame");

	a_arm_sets: assert property (
		arm |=> armed)
		else $error("arm pulse did not arm monitoring");

	a_armed_stays: assert property (
		armed && !accept |=> armed)
		else $error("monitoring dropped without an alert");

	a_unarmed_stays: assert property (
		!armed && !arm |=> !armed)
		else $error("monitoring armed itself");

	a_rx_pulse_one: assert property (
		rx_alert |=> !rx_alert)
		else $error("receive alert longer than one cycle");

	a_rx_chan_hold: assert property (
		!rx_alert |-> $stable(rx_alert_chan))
		else $error("receive channel changed without alert");

	c_stalled_byte: cover property (
		tx_valid && !tx_ready);
	c_full_frame: cover property (
		tx_valid && tx_last && tx_ready);
	c_rearm_same_cycle: cover property (
		accept && arm);
	c_drop_unarmed: cover property (
		alert_req && !armed);
	c_rx_alert: cover property (
		rx_alert);

endmodule

//--- verilog/bdaf_pkg.sv
// constants and header builder for the buffer depth alert framer
package bdaf_pkg;

	// ****************************************************
	// header geometry
	// ****************************************************
	localparam int HDR_BYTES = 8;
	localparam int BYTE_W    = 8;
	localparam int HDR_W     = HDR_BYTES * BYTE_W;

	localparam logic [2:0] LAST_BYTE = 3'h7;
	localparam logic [2:0] CHAN_BYTE = 3'h4;
	localparam logic [2:0] FUNC_BYTE = 3'h1;
	localparam logic [2:0] RSV2_BYTE = 3'h2;
	localparam logic [2:0] XACT_BYTE = 3'h3;
	localparam logic [3:0] RX_FULL   = 4'h8;

	// ****************************************************
	// field values as transmitted
	// ****************************************************
	localparam logic        CV_VAL     = 1'h0;
	localparam logic        SEQ_VAL    = 1'h0;
	localparam logic [1:0]  EXT_VAL    = 2'h1;
	localparam logic        X_VAL      = 1'h0;
	localparam logic [2:0]  STREAM_VAL = 3'h0;
	localparam logic [3:0]  RSV1_VAL   = 4'h0;
	localparam logic [3:0]  FUNC_ALERT = 4'h1;
	localparam logic [7:0]  RSV2_VAL   = 8'h00;
	localparam logic [7:0]  XACT_VAL   = 8'h00;
	localparam logic [7:0]  CHAN_NONE  = 8'h00;
	localparam logic [23:0] RSV3_VAL   = 24'h000000;

	// ****************************************************
	// field positions
	// ****************************************************
	localparam int B0_CV_BIT  = 7;
	localparam int B0_SEQ_BIT = 6;
	localparam int B0_EXT_LO  = 4;
	localparam int B0_X_BIT   = 3;
	localparam int B0_FLOW_LO = 0;
	localparam int B1_FUNC_LO = 0;
	localparam int B1_RSV_LO  = 4;
	localparam int EXT_LO     = 60;
	localparam int FUNC_LO    = 48;
	localparam int CHAN_LO    = 24;

	// whole 8-byte header, most significant bit first
	function automatic logic [HDR_W-1:0] build_header(
		input logic [7:0] chan
	);
		build_header = {CV_VAL, SEQ_VAL, EXT_VAL, X_VAL, STREAM_VAL,
			RSV1_VAL, FUNC_ALERT, RSV2_VAL, XACT_VAL, chan, RSV3_VAL};
	endfunction

endpackage

//--- verilog/bdaf_rx_if.sv
// parsed alert results passed from the receive parser to the framer
interface bdaf_rx_if;
	logic       alert_seen;
	logic [7:0] alert_chan;

	modport parser (
		output alert_seen,
		output alert_chan
	);
	modport user (
		input  alert_seen,
		input  alert_chan
	);
endinterface

//--- verilog/bdaf_rx_parser.sv
// receive parser for the 8-byte alert sublayer header
module bdaf_rx_parser (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// receive byte stream
	input  wire logic       rx_valid,
	input  wire logic [7:0] rx_data,
	input  wire logic       rx_first,
	// parsed results
	bdaf_rx_if.parser       rif
);

	logic [bdaf_pkg::HDR_W-1:0] shreg;
	logic [3:0]                 cnt;
	logic [bdaf_pkg::HDR_W-1:0] next_shreg;
	logic [3:0]                 next_cnt;
	logic                       done;

	assign next_shreg = {shreg[bdaf_pkg::HDR_W-bdaf_pkg::BYTE_W-1:0],
		rx_data};
	assign next_cnt   = rx_first ? 4'h1 : cnt + 4'h1;
	// bytes past the header are ignored until the next first byte
	assign done       = rx_valid && (rx_first || cnt < bdaf_pkg::RX_FULL)
		&& next_cnt == bdaf_pkg::RX_FULL;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shreg <= '0;
			cnt   <= 4'h0;
		end else if (rx_valid && (rx_first || cnt < bdaf_pkg::RX_FULL)) begin
			shreg <= next_shreg;
			cnt   <= next_cnt;
		end
	end

	// only the extension marker and function code are judged;
	// reserved, stream index and transaction bytes may hold anything
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rif.alert_seen <= 1'h0;
			rif.alert_chan <= 8'h00;
		end else begin
			rif.alert_seen <= done
				&& next_shreg[bdaf_pkg::EXT_LO +: 2] == bdaf_pkg::EXT_VAL
				&& next_shreg[bdaf_pkg::FUNC_LO +: 4]
					== bdaf_pkg::FUNC_ALERT;
			if (done)
				rif.alert_chan <= next_shreg[bdaf_pkg::CHAN_LO +: 8];
		end
	end

endmodule
